// file: remote_io_weight_data_formatter_defs.vh
// Constants for the remote I/O weight data formatter
// What this block does
// - Discrete words are refreshed continuously, also while block transfer is on.
// - Block transfer is offered only when configured, on top of discrete data.
// - Integer and division slots take a quarter rack: two words each way.
// - Float slots take half a rack: four words each way, value in two.
// - Integer format sends the selected weight as a signed count, decimal point dropped.
// - Division format sends the weight as a count of scale divisions.
// - Float format sends the weight as an IEEE single-precision number.
// - Only float carries the decimal point; otherwise the controller scales.
// - All quarters of the device sit contiguously within one logical rack.
// - Quarters needed follow format and slots; configurations that overflow are refused.
// - Status bits show uninterrupted delivery and absence of errors.
// - Bits 0-2 of a slot's second output word pick its returned weight.
// - Commands, downloads and output controls act only from the first slot.
`ifndef REMOTE_IO_WEIGHT_DATA_FORMATTER_DEFS_VH
`define REMOTE_IO_WEIGHT_DATA_FORMATTER_DEFS_VH

// ----------------------------------------
// Formats and rack geometry
// ----------------------------------------
`define FMT_INTEGER 2'h0
`define FMT_DIVISION 2'h1
`define FMT_FLOAT 2'h2
`define RACK_QUARTERS 3'h4
`define WORDS_PER_QUARTER 4'h2

// ----------------------------------------
// Reset configuration
// ----------------------------------------
`define RST_FORMAT 2'h0
`define RST_START_Q 2'h0
`define RST_SLOTS 3'h1
`define RST_BT_EN 1'b0

// ----------------------------------------
// Weight source select codes
// ----------------------------------------
`define SEL_DISPLAYED 3'h0
`define SEL_GROSS 3'h1
`define SEL_TARE 3'h2
`define SEL_NET 3'h3

// ----------------------------------------
// Status word bit positions
// ----------------------------------------
`define ST_DATA_OK 15
`define ST_UPDATE 14
`define ST_INTEGRITY 13
`define ST_ERROR 12
`define ST_SCALE_W 12

// ----------------------------------------
// Decimal scaling factors 10^-n as float mantissa and exponent drop
// ----------------------------------------
`define SCL_M0 24'h800000
`define SCL_M1 24'hcccccd
`define SCL_M2 24'ha3d70a
`define SCL_M3 24'h83126f
`define SCL_E0 8'h00
`define SCL_E1 8'h04
`define SCL_E2 8'h07
`define SCL_E3 8'h0a
`define FLT_BIAS 8'h7f
`define DIV_STEPS 6'h20

`endif

// file: remote_io_weight_data_formatter.v
// Discrete rack word formatter for the remote I/O weighing node
`timescale 1ns/100ps
`include "remote_io_weight_data_formatter_defs.vh"

module remote_io_weight_data_formatter (
	input wire clk,
	input wire sys_rst,
	input wire cfg_load,
	input wire [1:0] cfg_format,
	input wire [1:0] cfg_start_q,
	input wire [2:0] cfg_slots,
	input wire cfg_bt_en,
	input wire signed [31:0] wt_displayed,
	input wire signed [31:0] wt_gross,
	input wire signed [31:0] wt_tare,
	input wire [15:0] incr_size,
	input wire [1:0] dec_places,
	input wire [11:0] scale_status,
	input wire scale_error,
	input wire [127:0] rack_out_words,
	output reg [127:0] rack_in_words,
	output reg [1:0] format_cur,
	output reg [1:0] start_q_cur,
	output reg [2:0] slots_cur,
	output reg [2:0] quarters_used,
	output reg bt_enable,
	output reg cfg_reject,
	output reg scan_busy,
	output reg [15:0] cmd_word,
	output reg [15:0] cmd_data,
	output reg cmd_strobe
);

	localparam S_SEL = 3'h0;
	localparam S_DIV = 3'h1;
	localparam S_CONV = 3'h2;
	localparam S_WRITE = 3'h3;
	localparam S_DONE = 3'h4;

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	function [2:0] quarters_needed;
		input [1:0] fmt;
		input [2:0] slots;
		begin
			if (fmt == `FMT_FLOAT)
				quarters_needed = {slots[1:0], 1'b0};
			else
				quarters_needed = slots;
		end
	endfunction

	function [4:0] lead_one;
		input [31:0] m;
		integer i;
		begin
			lead_one = 5'h00;
			for (i = 0; i < 32; i = i + 1) begin
				if (m[i])
					lead_one = i[4:0];
			end
		end
	endfunction

	// Word index of a slot's first word inside the rack
	function [2:0] slot_base;
		input [1:0] startq;
		input [1:0] fmt;
		input [1:0] slot;
		begin
			if (fmt == `FMT_FLOAT)
				slot_base = {startq[1:0], 1'b0} + {slot[0], 2'b00};
			else
				slot_base = {startq[1:0], 1'b0} + {slot[1:0], 1'b0};
		end
	endfunction

	// ----------------------------------------
	// Configuration
	// ----------------------------------------
	wire [2:0] need_new;
	wire [3:0] need_wide;
	wire cfg_fits;

	assign need_new = quarters_needed(cfg_format, cfg_slots);
	// Four bits, so eight float quarters cannot wrap to zero and slip through
	assign need_wide = (cfg_format == `FMT_FLOAT) ? {cfg_slots, 1'b0} : {1'b0, cfg_slots};
	assign cfg_fits = (cfg_slots != 3'h0) && (cfg_format != 2'h3) && (cfg_slots <= 3'h4) &&
		(({2'h0, cfg_start_q} + need_wide) <= {1'b0, `RACK_QUARTERS});

	always @(posedge clk) begin
		if (sys_rst) begin
			format_cur <= `RST_FORMAT;
			start_q_cur <= `RST_START_Q;
			slots_cur <= `RST_SLOTS;
			quarters_used <= `RST_SLOTS;
			bt_enable <= `RST_BT_EN;
			cfg_reject <= 1'b0;
		end else begin
			cfg_reject <= cfg_load & ~cfg_fits;
			if (cfg_load && cfg_fits) begin
				format_cur <= cfg_format;
				start_q_cur <= cfg_start_q;
				slots_cur <= cfg_slots;
				quarters_used <= need_new;
				bt_enable <= cfg_bt_en;
			end
		end
	end

	wire cfg_apply;

	assign cfg_apply = cfg_load & cfg_fits;

	// ----------------------------------------
	// Scan engine
	// ----------------------------------------
	reg [2:0] state_reg;
	reg [1:0] slot_reg;
	reg [31:0] mag_reg;
	reg neg_reg;
	reg [31:0] quot_reg;
	reg [16:0] rem_reg;
	reg [5:0] cnt_reg;
	reg [31:0] float_reg;
	reg [15:0] int_reg;
	reg integrity_reg;

	wire [2:0] base_w;
	wire [15:0] sel_word;
	reg signed [31:0] src;
	wire [15:0] divisor;
	wire [16:0] rem_sh;

	assign base_w = slot_base(start_q_cur, format_cur, slot_reg);
	assign sel_word = rack_out_words[{base_w + 3'h1, 4'h0} +: 16];
	assign divisor = (incr_size == 16'h0000) ? 16'h0001 : incr_size;
	assign rem_sh = {rem_reg[15:0], quot_reg[31]};

	always @* begin
		case (sel_word[2:0])
			`SEL_DISPLAYED: src = wt_displayed;
			`SEL_GROSS: src = wt_gross;
			`SEL_TARE: src = wt_tare;
			`SEL_NET: src = wt_gross - wt_tare;
			default: src = 32'h00000000;
		endcase
	end

	// Integer to float with decimal scaling; truncation keeps the path short
	reg [4:0] lead;
	reg [31:0] norm;
	reg [23:0] scl_m;
	reg [7:0] scl_e;
	reg [47:0] prod;
	reg [22:0] frac;
	reg [7:0] expo;
	reg [31:0] float_next;

	always @* begin
		lead = lead_one(mag_reg);
		norm = mag_reg << (5'd31 - lead);
		case (dec_places)
			2'h0: begin
				scl_m = `SCL_M0;
				scl_e = `SCL_E0;
			end
			2'h1: begin
				scl_m = `SCL_M1;
				scl_e = `SCL_E1;
			end
			2'h2: begin
				scl_m = `SCL_M2;
				scl_e = `SCL_E2;
			end
			default: begin
				scl_m = `SCL_M3;
				scl_e = `SCL_E3;
			end
		endcase
		prod = norm[31:8] * scl_m;
		if (prod[47]) begin
			frac = prod[46:24];
			expo = `FLT_BIAS + {3'h0, lead} - scl_e + 8'h01;
		end else begin
			frac = prod[45:23];
			expo = `FLT_BIAS + {3'h0, lead} - scl_e;
		end
		if (mag_reg == 32'h00000000)
			float_next = 32'h00000000;
		else
			float_next = {neg_reg, expo, frac};
	end

	wire [15:0] status_word;

	assign status_word = {~scale_error, 1'b1, integrity_reg, scale_error, scale_status};

	wire [15:0] div_signed;

	assign div_signed = neg_reg ? (16'h0000 - quot_reg[15:0]) : quot_reg[15:0];

	always @(posedge clk) begin
		if (sys_rst) begin
			state_reg <= S_SEL;
			slot_reg <= 2'h0;
			mag_reg <= 32'h00000000;
			neg_reg <= 1'b0;
			quot_reg <= 32'h00000000;
			rem_reg <= 17'h00000;
			cnt_reg <= 6'h00;
			float_reg <= 32'h00000000;
			int_reg <= 16'h0000;
			integrity_reg <= 1'b0;
			scan_busy <= 1'b0;
			rack_in_words <= 128'h0;
		end else if (cfg_apply) begin
			// Old layout is meaningless once the map moves
			state_reg <= S_SEL;
			slot_reg <= 2'h0;
			scan_busy <= 1'b0;
			rack_in_words <= 128'h0;
		end else begin
			case (state_reg)
				S_SEL: begin
					scan_busy <= 1'b1;
					neg_reg <= src[31];
					mag_reg <= src[31] ? (32'h00000000 - src) : src;
					quot_reg <= src[31] ? (32'h00000000 - src) : src;
					rem_reg <= 17'h00000;
					cnt_reg <= `DIV_STEPS;
					int_reg <= src[15:0];
					if (format_cur == `FMT_DIVISION)
						state_reg <= S_DIV;
					else if (format_cur == `FMT_FLOAT)
						state_reg <= S_CONV;
					else
						state_reg <= S_WRITE;
				end
				S_DIV: begin
					if (rem_sh >= {1'b0, divisor}) begin
						rem_reg <= rem_sh - {1'b0, divisor};
						quot_reg <= {quot_reg[30:0], 1'b1};
					end else begin
						rem_reg <= rem_sh;
						quot_reg <= {quot_reg[30:0], 1'b0};
					end
					cnt_reg <= cnt_reg - 6'h01;
					if (cnt_reg == 6'h01)
						state_reg <= S_WRITE;
				end
				S_CONV: begin
					float_reg <= float_next;
					state_reg <= S_WRITE;
				end
				S_WRITE: begin
					if (format_cur == `FMT_FLOAT) begin
						rack_in_words[{base_w, 4'h0} +: 16] <= float_reg[31:16];
						rack_in_words[{base_w + 3'h1, 4'h0} +: 16] <= float_reg[15:0];
						rack_in_words[{base_w + 3'h2, 4'h0} +: 16] <= status_word;
						rack_in_words[{base_w + 3'h3, 4'h0} +: 16] <= 16'h0000;
					end else begin
						if (format_cur == `FMT_DIVISION)
							rack_in_words[{base_w, 4'h0} +: 16] <= div_signed;
						else
							rack_in_words[{base_w, 4'h0} +: 16] <= int_reg;
						rack_in_words[{base_w + 3'h1, 4'h0} +: 16] <= status_word;
					end
					if ({1'b0, slot_reg} == slots_cur - 3'h1) begin
						state_reg <= S_DONE;
					end else begin
						slot_reg <= slot_reg + 2'h1;
						state_reg <= S_SEL;
					end
				end
				S_DONE: begin
					// Free-running rescan keeps discrete data flowing
					scan_busy <= 1'b0;
					integrity_reg <= ~integrity_reg;
					slot_reg <= 2'h0;
					state_reg <= S_SEL;
				end
				default: begin
					state_reg <= S_SEL;
					slot_reg <= 2'h0;
				end
			endcase
		end
	end

	// ----------------------------------------
	// First-slot command port
	// ----------------------------------------
	wire [2:0] cmd_base;
	wire [15:0] cmd_in;

	assign cmd_base = {start_q_cur, 1'b0};
	assign cmd_in = rack_out_words[{cmd_base + 3'h1, 4'h0} +: 16];

	always @(posedge clk) begin
		if (sys_rst) begin
			cmd_word <= 16'h0000;
			cmd_data <= 16'h0000;
			cmd_strobe <= 1'b0;
		end else begin
			// Select bits alone are not commands
			cmd_strobe <= (cmd_in[15:3] != cmd_word[15:3]) && (cmd_in[15:3] != 13'h0000);
			cmd_word <= cmd_in;
			cmd_data <= rack_out_words[{cmd_base, 4'h0} +: 16];
		end
	end

endmodule

// file: fmt_check_assertions.sv
// Checker on the formatter's configuration and command ports
`timescale 1ns/100ps
module fmt_check (
	input wire clk,
	input wire sys_rst,
	input wire cfg_load,
	input wire [1:0] cfg_format,
	input wire [1:0] cfg_start_q,
	input wire [2:0] cfg_slots,
	input wire cfg_bt_en,
	input wire [127:0] rack_out_words,
	input wire [1:0] format_cur,
	input wire [1:0] start_q_cur,
	input wire [2:0] slots_cur,
	input wire [2:0] quarters_used,
	input wire bt_enable,
	input wire cfg_reject,
	input wire [15:0] cmd_word,
	input wire [15:0] cmd_data,
	input wire cmd_strobe
);
	wire [3:0] need = (cfg_format == 2'h2) ? {cfg_slots, 1'b0} : {1'b0, cfg_slots};
	wire fits = cfg_format != 2'h3 && cfg_slots != 3'h0 && {2'h0, cfg_start_q} + need <= 4'h4;
	wire [15:0] cmd_src = rack_out_words[32 * start_q_cur + 16 +: 16];
	wire [15:0] dat_src = rack_out_words[32 * start_q_cur +: 16];
	default clocking @(posedge clk); endclocking
	default disable iff (sys_rst);
	a_reject_bad_cfg: assert property (cfg_load && !fits |=> cfg_reject && $stable(slots_cur))
		else $error("unfit config not refused");
	a_accept_cfg: assert property (cfg_load && fits |=> !cfg_reject &&
		format_cur == $past(cfg_format) && start_q_cur == $past(cfg_start_q)
		&& slots_cur == $past(cfg_slots)) else $error("fitting config not applied");
	a_bt_follow: assert property (cfg_load && fits |=> bt_enable == $past(cfg_bt_en))
		else $error("block transfer flag wrong");
	a_quarter_count: assert property (quarters_used ==
		(format_cur == 2'h2 ? {slots_cur[1:0], 1'b0} : slots_cur)) else $error("quarter count");
	a_quarter_fit: assert property ({2'h0, start_q_cur} + {1'b0, quarters_used} <= 4'h4)
		else $error("quarters overflow rack");
	a_reject_cause: assert property (cfg_reject |-> $past(cfg_load) && !$past(fits))
		else $error("spurious refusal");
	a_cfg_hold: assert property (!$past(cfg_load) |-> $stable(format_cur) &&
		$stable(start_q_cur)) else $error("config changed without load");
	a_cmd_follow: assert property ($stable(start_q_cur) && !$past(sys_rst) &&
		(format_cur != 2'h2 || start_q_cur == 2'h0) |-> cmd_word == $past(cmd_src))
		else $error("command word not from first slot");
	a_strobe_rule: assert property (!$past(sys_rst) |-> cmd_strobe ==
		(cmd_word[15:3] != 13'h0 && cmd_word[15:3] != $past(cmd_word[15:3])))
		else $error("command strobe wrong");
	a_cmd_data_follow: assert property ($stable(start_q_cur) && !$past(sys_rst) |->
		cmd_data == $past(dat_src)) else $error("command data not from first slot");
endmodule

// file: plc_model.sv
// Controller side model driving the rack output words
`timescale 1ns/100ps
module plc_model (
	input wire clk,
	input wire [1:0] start_q,
	input wire [2:0] slots,
	input wire flt,
	input wire [11:0] sel,
	input wire [15:0] cmd,
	output reg [127:0] rack_out_words
);
	reg [7:0] spin_reg = 8'h00;
	integer k;
	integer b;
	initial rack_out_words = 128'h0;
	always @(posedge clk) begin
		spin_reg <= spin_reg + 8'h01;
		// Unused words churn so nothing stale looks valid
		for (k = 0; k < 8; k = k + 1)
			rack_out_words[16 * k +: 16] <= {spin_reg, ~spin_reg};
		for (k = 0; k < 4; k = k + 1) begin
			b = 2 * start_q + (flt ? 4 : 2) * k;
			if (k < slots && b < 8)
				rack_out_words[16 * b + 16 +: 16] <= {k == 0 ? cmd[15:3] : 13'h0, sel[3 * k +: 3]};
		end
	end
endmodule

// file: remote_io_weight_data_formatter_bench.sv
// Self-checking bench for the weight data formatter
`timescale 1ns/100ps
module remote_io_weight_data_formatter_bench;
	reg clk = 1'b0;
	reg sys_rst, cfg_load, cfg_bt_en, scale_error;
	reg [1:0] cfg_format, cfg_start_q, dec_places, q, f;
	reg [2:0] cfg_slots;
	reg signed [31:0] wt_displayed, wt_gross, wt_tare;
	reg [15:0] incr_size, cmd;
	reg [11:0] scale_status, sel;
	reg [31:0] r;
	wire [127:0] rack_out_words, rack_in_words;
	wire [1:0] format_cur, start_q_cur;
	wire [2:0] slots_cur, quarters_used;
	wire bt_enable, cfg_reject, scan_busy, cmd_strobe;
	wire [15:0] cmd_word, cmd_data;
	wire [15:0] st_exp = {~scale_error, 1'b1, 1'b0, scale_error, scale_status};
	integer failures, samples_checked, i, k;
	reg tog_last, tog_seen;
	localparam [41:0] BAD = {2'h2, 2'h0, 3'h4, 2'h3, 2'h0, 3'h1, 2'h0, 2'h0, 3'h0,
		2'h0, 2'h3, 3'h2, 2'h2, 2'h1, 3'h2, 2'h0, 2'h0, 3'h5};
	always #25 clk = ~clk;
	remote_io_weight_data_formatter remote_io_weight_data_formatter_inst (.clk, .sys_rst,
		.cfg_load, .cfg_format, .cfg_start_q, .cfg_slots, .cfg_bt_en, .wt_displayed,
		.wt_gross, .wt_tare, .incr_size, .dec_places, .scale_status, .scale_error,
		.rack_out_words, .rack_in_words, .format_cur, .start_q_cur, .slots_cur,
		.quarters_used, .bt_enable, .cfg_reject, .scan_busy, .cmd_word, .cmd_data, .cmd_strobe);
	plc_model plc_model_inst (.clk, .start_q(start_q_cur), .slots(slots_cur),
		.flt(format_cur == 2'h2), .sel, .cmd, .rack_out_words);
	task complete_run;
		begin
			if (failures == 0 && samples_checked > 0)
				$display("No errors found");
			else
				$display("Errors were found");
			$finish;
		end
	endtask
	task chk(input [15:0] got, input [15:0] exp);
		begin
			samples_checked = samples_checked + 1;
			if (got !== exp) begin
				failures = failures + 1;
				$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
			end
		end
	endtask
	task setcfg(input [1:0] fm, input [1:0] sq, input [2:0] sl, input bt);
		begin
			@(posedge clk);
			cfg_load <= 1'b1;
			cfg_format <= fm;
			cfg_start_q <= sq;
			cfg_slots <= sl;
			cfg_bt_en <= bt;
			@(posedge clk);
			cfg_load <= 1'b0;
			@(negedge clk);
		end
	endtask
	// Two finished scans guarantee one began after the last input change
	task scan2;
		integer n, d;
		reg b;
		begin
			d = 0;
			b = 1'b0;
			for (n = 0; n < 2000 && d < 2; n = n + 1) begin
				@(negedge clk);
				if (b && scan_busy === 1'b0)
					d = d + 1;
				b = scan_busy === 1'b1;
			end
			if (d < 2) begin
				failures = failures + 1;
				complete_run;
			end
		end
	endtask
	function [15:0] ew(input [2:0] s, input [1:0] fm);
		reg signed [31:0] w;
		begin
			w = s == 3'h0 ? wt_displayed : s == 3'h1 ? wt_gross : s == 3'h2 ? wt_tare :
				s == 3'h3 ? wt_gross - wt_tare : 32'sh0;
			if (fm == 2'h1)
				w = w / $signed({16'h0, incr_size == 16'h0 ? 16'h0001 : incr_size});
			ew = w[15:0];
		end
	endfunction
	initial begin
		failures = 0;
		samples_checked = 0;
		tog_seen = 1'b0;
		tog_last = 1'b0;
		{sys_rst, cfg_load, cfg_format, cfg_start_q, cfg_slots, cfg_bt_en} = 10'h201;
		{wt_displayed, wt_gross, wt_tare, dec_places, scale_status, scale_error} = 0;
		incr_size = 16'h0001;
		sel = 12'h000;
		cmd = 16'h0000;
		r = $urandom(32'h4f89fad1);
		repeat (20) @(posedge clk);
		sys_rst <= 1'b0;
		@(negedge clk);
		chk({9'h0, format_cur, start_q_cur, slots_cur}, 16'h0001);
		for (i = 0; i < 8; i = i + 1) begin
			r = $urandom;
			q = r[1:0];
			f = {1'b0, i[0]};
			setcfg(f, q, 3'h4 - q, i[1]);
			chk({9'h0, bt_enable, quarters_used, slots_cur}, {9'h0, i[1], 3'h4 - q, 3'h4 - q});
			@(posedge clk);
			wt_displayed <= (i < 2) ? 32'sd50000 : $urandom;
			wt_gross <= $urandom;
			wt_tare <= $urandom % 1000;
			incr_size <= (i == 1) ? 16'h000a : $urandom % 20;
			sel <= (i < 2) ? 12'h000 : $urandom;
			scale_status <= $urandom;
			scale_error <= $urandom;
			scan2;
			for (k = 0; k < 4 - q; k = k + 1) begin
				chk(rack_in_words[32 * (q + k) +: 16], ew(sel[3 * k +: 3], f));
				chk(rack_in_words[32 * (q + k) + 16 +: 16] & 16'hdfff, st_exp);
			end
		end
		setcfg(2'h2, 2'h0, 3'h2, 1'b1);
		chk({9'h0, bt_enable, quarters_used, slots_cur}, {9'h0, 1'b1, 3'h4, 3'h2});
		@(posedge clk);
		wt_displayed <= 32'sd1355;
		wt_gross <= -32'sd1355;
		sel <= 12'h008;
		scan2;
		chk(rack_in_words[15:0], 16'h44a9);
		chk(rack_in_words[31:16], 16'h6000);
		chk(rack_in_words[47:32] & 16'hdfff, st_exp);
		chk(rack_in_words[63:48], 16'h0000);
		chk(rack_in_words[79:64], 16'hc4a9);
		@(posedge clk);
		dec_places <= 2'h1;
		scan2;
		chk(rack_in_words[15:0], 16'h4307);
		for (i = 0; i < 6; i = i + 1) begin
			setcfg(BAD[7 * i + 5 +: 2], BAD[7 * i + 3 +: 2], BAD[7 * i +: 3], 1'b0);
			chk({15'h0, cfg_reject}, 16'h0001);
			chk({9'h0, format_cur, start_q_cur, slots_cur}, 16'h0042);
		end
		setcfg(2'h0, 2'h0, 3'h1, 1'b0);
		@(posedge clk);
		sel <= 12'h000;
		cmd <= 16'h0010;
		repeat (3) @(negedge clk);
		chk({cmd_strobe, cmd_word[14:0]}, 16'h8010);
		@(negedge clk);
		chk({cmd_strobe, cmd_word[14:0]}, 16'h0010);
		chk(cmd_word, 16'h0010);
		// Each finished one-slot scan must flip the integrity bit
		for (i = 0; i < 12; i = i + 1) begin
			@(negedge clk);
			if (scan_busy === 1'b0) begin
				if (tog_seen)
					chk({15'h0, rack_in_words[29]}, {15'h0, ~tog_last});
				tog_last = rack_in_words[29];
				tog_seen = 1'b1;
			end
		end
		complete_run;
	end
endmodule
bind remote_io_weight_data_formatter fmt_check fmt_check_inst (.clk, .sys_rst, .cfg_load,
	.cfg_format, .cfg_start_q, .cfg_slots, .cfg_bt_en, .rack_out_words, .format_cur,
	.start_q_cur, .slots_cur, .quarters_used, .bt_enable, .cfg_reject, .cmd_word, .cmd_data,
	.cmd_strobe);
